// ==== i2c_slave_receive_path.sv ====
// Function
// - After address cleared, shift bytes into data
// - Acknowledge each byte only when enabled
// - Set receive flag; interrupt needs both enables
// - Unread data at byte end stretches clock
// - Status read then data read clears
// - Stop condition sets stop flag, interrupt
// - Status read then control write clears stop
// - Address match acknowledges, sets match flag
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "i2c_rx_defs.svh"
`timescale 1ns/1ns
module i2c_slave_receive_path
  import i2c_rx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);

  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  rx_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] data_reg;
  logic [`CTRL_WIDTH-1:0] ctrl_reg;
  logic [6:0] own_addr_reg;
  logic addr_matched_reg;
  logic byte_done_reg;
  logic rx_avail_reg;
  logic stop_reg;
  logic stat1_seen_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic line_low_reg;
  logic irq_reg;
  logic [31:0] rd_data;
  logic mapped;

  // Reset leaves synchronously after two clock edges, enters at once
  sync_two_flop #(.RESET_VALUE(1'b0)) u_rst_sync (
    .clk(clk),
    .rst_n(reset_n),
    .d(1'b1),
    .q(rst_n)
  );

  // Idle bus lines read high
  sync_two_flop #(.RESET_VALUE(1'b1)) u_scl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(scl_in),
    .q(scl_s)
  );

  sync_two_flop #(.RESET_VALUE(1'b1)) u_sda_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(sda_in),
    .q(sda_s)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_evt = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  wire stop_evt = scl_s && scl_d_reg && sda_s && !sda_d_reg;

  // Bus decode; side effects only at the completing edge
  wire setup = psel && !penable;
  wire access = psel && penable && pready_reg;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire rd_stat1 = rd && (paddr == `STAT1_OFFSET);
  wire rd_stat2 = rd && (paddr == `STAT2_OFFSET);
  wire rd_data_reg = rd && (paddr == `DATA_OFFSET);
  wire wr_ctrl = wr && (paddr == `CTRL_OFFSET);

  wire enable = ctrl_reg[`CTRL_ENABLE];
  wire ack_en = ctrl_reg[`CTRL_ACK_ENABLE];
  wire evt_irq_en = ctrl_reg[`CTRL_EVENT_IRQ_ENABLE];
  wire buf_irq_en = ctrl_reg[`CTRL_BUFFER_IRQ_ENABLE];

  // Completion points of the receive sequence
  wire byte_end = (state_reg == ST_DATA) && scl_fall
    && (bit_cnt_reg == `BITS_PER_BYTE);
  wire addr_end = (state_reg == ST_ADDR) && scl_fall
    && (bit_cnt_reg == `BITS_PER_BYTE);
  wire addr_hit = addr_end && (shift_reg[7:1] == own_addr_reg)
    && !shift_reg[0];
  wire aack_done = (state_reg == ST_ADDR_ACK) && scl_fall;
  wire dack_done = (state_reg == ST_DATA_ACK) && scl_fall;
  wire stop_set = stop_evt && (state_reg != ST_IDLE);
  wire addr_clr = rd_stat2 && stat1_seen_reg;
  wire byte_done_clr = rd_data_reg && stat1_seen_reg;
  wire stop_clr = wr_ctrl && stat1_seen_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (!enable) begin
      state_reg <= ST_IDLE;
    end else if (stop_evt) begin
      state_reg <= ST_IDLE;
    end else if (start_evt) begin
      state_reg <= ST_ADDR;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_ADDR: begin
          if (addr_hit) begin
            state_reg <= ST_ADDR_ACK;
          end else if (addr_end) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_ADDR_WAIT;
          end
        end
        ST_ADDR_WAIT: begin
          if (!addr_matched_reg) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_end && rx_avail_reg) begin
            state_reg <= ST_HOLD;
          end else if (byte_end) begin
            state_reg <= ST_DATA_ACK;
          end
        end
        ST_HOLD: begin
          if (!byte_done_reg) begin
            state_reg <= ST_DATA_ACK;
          end
        end
        ST_DATA_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_DATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `BYTE_RESET;
      bit_cnt_reg <= `BIT_COUNT_ZERO;
    end else if (start_evt || aack_done || dack_done) begin
      bit_cnt_reg <= `BIT_COUNT_ZERO;
    end else if (scl_rise && (bit_cnt_reg != `BITS_PER_BYTE)
        && (state_reg == ST_ADDR || state_reg == ST_DATA)) begin
      shift_reg <= {shift_reg[6:0], sda_s};
      bit_cnt_reg <= bit_cnt_reg + `BIT_COUNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= `BYTE_RESET;
    end else if (dack_done) begin
      data_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_n_reg <= 1'b1;
    end else if (addr_hit || (state_reg == ST_DATA && byte_end
        && !rx_avail_reg) || (state_reg == ST_HOLD
        && !byte_done_reg)) begin
      sda_oe_n_reg <= !ack_en;
    end else if (aack_done || dack_done || !enable || stop_evt) begin
      sda_oe_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_n_reg <= 1'b1;
    end else begin
      scl_oe_n_reg <= !(aack_done || (state_reg == ST_ADDR_WAIT
        && addr_matched_reg) || (byte_end && rx_avail_reg)
        || (state_reg == ST_HOLD && byte_done_reg));
    end
  end

  // Pins are only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_low_reg <= 1'b0;
    end else begin
      line_low_reg <= 1'b0;
    end
  end

  // Tracks a status one read as the last access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat1_seen_reg <= 1'b0;
    end else if (access) begin
      stat1_seen_reg <= rd_stat1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_matched_reg <= 1'b0;
    end else begin
      addr_matched_reg <= aack_done || (addr_matched_reg && !addr_clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_done_reg <= 1'b0;
    end else begin
      byte_done_reg <= (byte_end && rx_avail_reg)
        || (byte_done_reg && !byte_done_clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_avail_reg <= 1'b0;
    end else begin
      rx_avail_reg <= dack_done || (rx_avail_reg && !rd_data_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= stop_set || (stop_reg && !stop_clr);
    end
  end

  wire [`IRQ_WIDTH-1:0] irq_set = {stop_set && evt_irq_en,
    dack_done && evt_irq_en && buf_irq_en, aack_done && evt_irq_en};
  wire [`IRQ_WIDTH-1:0] irq_w1c = (wr && paddr == `IRQ_STATUS_OFFSET)
    ? pwdata[`IRQ_WIDTH-1:0] : `IRQ_RESET;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= `IRQ_RESET;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg & ~irq_w1c);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
      own_addr_reg <= `OWN_ADDR_RESET;
      irq_mask_reg <= `IRQ_RESET;
    end else if (wr) begin
      if (paddr == `CTRL_OFFSET) begin
        ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
      end
      if (paddr == `OWN_ADDR_OFFSET) begin
        own_addr_reg <= pwdata[6:0];
      end
      if (paddr == `IRQ_MASK_OFFSET) begin
        irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `CTRL_OFFSET: rd_data[`CTRL_WIDTH-1:0] = ctrl_reg;
      `OWN_ADDR_OFFSET: rd_data[6:0] = own_addr_reg;
      `STAT1_OFFSET: begin
        rd_data[`STAT1_ADDR_MATCHED] = addr_matched_reg;
        rd_data[`STAT1_BYTE_DONE] = byte_done_reg;
        rd_data[`STAT1_STOP] = stop_reg;
        rd_data[`STAT1_RX_AVAIL] = rx_avail_reg;
      end
      `STAT2_OFFSET: rd_data[`STAT2_BUSY] = (state_reg != ST_IDLE);
      `DATA_OFFSET: rd_data[7:0] = data_reg;
      `IRQ_STATUS_OFFSET: rd_data[`IRQ_WIDTH-1:0] = irq_status_reg;
      `IRQ_MASK_OFFSET: rd_data[`IRQ_WIDTH-1:0] = irq_mask_reg;
      default: mapped = 1'b0;
    endcase
  end

  // No wait state: answer ready in the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign scl_out = line_low_reg;
  assign sda_out = line_low_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign irq = irq_reg;

  property p_data_load;
    @(posedge clk) disable iff (!rst_n)
    dack_done |=> rx_avail_reg && (data_reg == $past(shift_reg));
  endproperty
  a_data_load: assert property (p_data_load)
    else $error("Byte not moved to data register");

  property p_no_ack_outside;
    @(posedge clk) disable iff (!rst_n)
    (state_reg != ST_ADDR_ACK && state_reg != ST_DATA_ACK) |-> sda_oe_n_reg;
  endproperty
  a_no_ack_outside: assert property (p_no_ack_outside)
    else $error("Data line driven outside acknowledge");

  property p_no_ack_disabled;
    @(posedge clk) disable iff (!rst_n)
    (byte_end && !rx_avail_reg && !ack_en) |=> sda_oe_n_reg;
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled)
    else $error("Acknowledge driven while disabled");

  property p_rx_irq;
    @(posedge clk) disable iff (!rst_n)
    (dack_done && evt_irq_en && buf_irq_en) |=> irq_status_reg[`IRQ_RX]
      ##2 (irq || !irq_mask_reg[`IRQ_RX] || $past(irq_w1c[`IRQ_RX]));
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("Receive interrupt missing");

  property p_hold_stretch;
    @(posedge clk) disable iff (!rst_n)
    (byte_end && rx_avail_reg) |=> byte_done_reg && !scl_oe_n_reg;
  endproperty
  a_hold_stretch: assert property (p_hold_stretch)
    else $error("Clock not stretched on overrun");

  property p_byte_done_clear;
    @(posedge clk) disable iff (!rst_n)
    $fell(byte_done_reg) |-> $past(rd_data_reg && stat1_seen_reg);
  endproperty
  a_byte_done_clear: assert property (p_byte_done_clear)
    else $error("Byte done cleared without sequence");

  property p_addr_clear;
    @(posedge clk) disable iff (!rst_n)
    $fell(addr_matched_reg) |-> $past(rd_stat2 && stat1_seen_reg);
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("Match flag cleared without sequence");

  property p_rx_clear;
    @(posedge clk) disable iff (!rst_n)
    (rd_data_reg && !dack_done) |=> !rx_avail_reg;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("Data read left receive flag set");

  property p_stop_set;
    @(posedge clk) disable iff (!rst_n)
    stop_set |=> stop_reg && (state_reg == ST_IDLE);
  endproperty
  a_stop_set: assert property (p_stop_set)
    else $error("Stop not flagged");

  property p_stop_clear;
    @(posedge clk) disable iff (!rst_n)
    $fell(stop_reg) |-> $past(wr_ctrl && stat1_seen_reg);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("Stop flag cleared without sequence");

  property p_addr_set;
    @(posedge clk) disable iff (!rst_n)
    addr_hit |=> (state_reg == ST_ADDR_ACK) && (sda_oe_n_reg == !$past(ack_en));
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("Address match not acknowledged");

  property p_addr_stretch;
    @(posedge clk) disable iff (!rst_n)
    aack_done |=> addr_matched_reg && !scl_oe_n_reg;
  endproperty
  a_addr_stretch: assert property (p_addr_stretch)
    else $error("Clock not held after match");

  c_addr_match: cover property (@(posedge clk) disable iff (!rst_n)
    aack_done);
  c_byte_rx: cover property (@(posedge clk) disable iff (!rst_n)
    dack_done);
  c_overrun: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(byte_done_reg));
  c_stop: cover property (@(posedge clk) disable iff (!rst_n)
    stop_set);

endmodule

// ==== i2c_rx_defs.svh ====
`ifndef I2C_RX_DEFS_SVH
`define I2C_RX_DEFS_SVH

// Register byte offsets
`define CTRL_OFFSET 8'h00
`define OWN_ADDR_OFFSET 8'h04
`define STAT1_OFFSET 8'h08
`define STAT2_OFFSET 8'h0c
`define DATA_OFFSET 8'h10
`define IRQ_STATUS_OFFSET 8'h14
`define IRQ_MASK_OFFSET 8'h18

// control_register_one fields
`define CTRL_ENABLE 0
`define CTRL_ACK_ENABLE 1
`define CTRL_EVENT_IRQ_ENABLE 2
`define CTRL_BUFFER_IRQ_ENABLE 3
`define CTRL_WIDTH 4
`define CTRL_RESET 4'h0

// status_register_one and status_register_two fields
`define STAT1_ADDR_MATCHED 0
`define STAT1_BYTE_DONE 2
`define STAT1_STOP 4
`define STAT1_RX_AVAIL 6
`define STAT2_BUSY 1

// Interrupt status and mask fields
`define IRQ_ADDR 0
`define IRQ_RX 1
`define IRQ_STOP 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

`define OWN_ADDR_RESET 7'h00
`define BYTE_RESET 8'h00
`define BITS_PER_BYTE 4'h8
`define BIT_COUNT_ZERO 4'h0
`define BIT_COUNT_ONE 4'h1

`endif

// ==== i2c_rx_pkg.sv ====
package i2c_rx_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_ADDR_WAIT = 7'h08,
    ST_DATA = 7'h10,
    ST_HOLD = 7'h20,
    ST_DATA_ACK = 7'h40
  } rx_state_t;

endpackage

// ==== sync_two_flop.sv ====
`timescale 1ns/1ns
module sync_two_flop #(
  parameter bit RESET_VALUE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta_reg;

  // Only the second stage is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== i2c_master_model.sv ====
`timescale 1ns/1ns
module i2c_master_model (
  input wire logic clk,
  input wire logic scl_wire,
  input wire logic sda_wire,
  output logic scl_drv,
  output logic sda_drv
);
  int n_timeouts = 0;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clock_high();
    int i;
    scl_drv <= 1'b1;
    i = 0;
    @(posedge clk);
    while (scl_wire !== 1'b1 && i < 4000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 4000) n_timeouts++;
    hold(4);
  endtask
  // Data moves only while clock low
  task automatic send_bit(input logic b, output logic seen);
    hold(2);
    sda_drv <= b;
    hold(2);
    clock_high();
    seen = sda_wire;
    scl_drv <= 1'b0;
  endtask
  task automatic start();
    sda_drv <= 1'b0;
    hold(4);
    scl_drv <= 1'b0;
  endtask
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(b[i], s);
    send_bit(1'b1, ack);
  endtask
  task automatic stop();
    hold(2);
    sda_drv <= 1'b0;
    hold(2);
    clock_high();
    sda_drv <= 1'b1;
    hold(4);
  endtask
endmodule

// ==== test_i2c_slave_receive_path.sv ====
`timescale 1ns/1ns
`include "i2c_rx_defs.svh"
module test_i2c_slave_receive_path;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
  logic scl_drv, sda_drv, scl_wire, sda_wire;
  logic [31:0] v;
  logic e, a0, a1, a2, a3;
  int n_errors = 0;
  int checked = 0;
  assign scl_wire = scl_drv & (scl_oe_n | scl_out);
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  always #25 clk = ~clk;
  i2c_slave_receive_path i2c_slave_receive_path_i (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_wire), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq));
  i2c_master_model i2c_master_model_i (.clk(clk), .scl_wire(scl_wire),
    .sda_wire(sda_wire), .scl_drv(scl_drv), .sda_drv(sda_drv));
  task automatic chk_word(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_bit(string n, logic x, logic g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", n, x, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
      output logic [31:0] r, output logic er);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) n_errors++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r, e);
  endtask
  // Polls status one; the last access left is that read
  task automatic wait_stat1(int b, output logic [31:0] r);
    int i;
    i = 0;
    do begin
      rd(`STAT1_OFFSET, r);
      i++;
    end while (r[b] !== 1'b1 && i < 400);
    if (r[b] !== 1'b1) n_errors++;
  endtask
  task automatic t_reset();
    rd(`STAT1_OFFSET, v);
    chk_word("stat1", 32'h0, v);
    rd(`CTRL_OFFSET, v);
    chk_word("ctrl", 32'h0, v);
    rd(8'h20, v);
    chk_bit("slverr", 1'b1, e);
    chk_word("unmapped", 32'h0, v);
    chk_bit("scl out", 1'b0, scl_out);
    chk_bit("sda out", 1'b0, sda_out);
    wr(`OWN_ADDR_OFFSET, 32'h2a);
    wr(`CTRL_OFFSET, 32'hf);
    wr(`IRQ_MASK_OFFSET, 32'h7);
  endtask
  task automatic t_frame();
    fork
      begin
        i2c_master_model_i.start();
        i2c_master_model_i.write_byte(8'h54, a0);
        i2c_master_model_i.write_byte(8'ha5, a1);
        i2c_master_model_i.write_byte(8'h3c, a2);
        i2c_master_model_i.write_byte(8'h96, a3);
        i2c_master_model_i.stop();
      end
      begin
        wait_stat1(`STAT1_ADDR_MATCHED, v);
        chk_bit("addr", 1'b1, v[`STAT1_ADDR_MATCHED]);
        chk_bit("irq", 1'b1, irq);
        chk_bit("stretch", 1'b0, scl_oe_n);
        rd(`STAT2_OFFSET, v);
        rd(`STAT1_OFFSET, v);
        chk_bit("addr clr", 1'b0, v[`STAT1_ADDR_MATCHED]);
        wait_stat1(`STAT1_RX_AVAIL, v);
        rd(`IRQ_STATUS_OFFSET, v);
        chk_bit("rx irq", 1'b1, v[`IRQ_RX]);
        rd(`DATA_OFFSET, v);
        chk_word("byte1", 32'ha5, v);
        rd(`STAT1_OFFSET, v);
        chk_bit("rx clr", 1'b0, v[`STAT1_RX_AVAIL]);
        wait_stat1(`STAT1_BYTE_DONE, v);
        chk_bit("hold stretch", 1'b0, scl_oe_n);
        rd(`DATA_OFFSET, v);
        chk_word("older", 32'h3c, v);
        wait_stat1(`STAT1_RX_AVAIL, v);
        chk_bit("done clr", 1'b0, v[`STAT1_BYTE_DONE]);
        rd(`DATA_OFFSET, v);
        chk_word("byte3", 32'h96, v);
      end
    join
    chk_bit("addr ack", 1'b0, a0);
    chk_bit("ack", 1'b0, a1 | a2 | a3);
    wait_stat1(`STAT1_STOP, v);
    chk_bit("stop", 1'b1, v[`STAT1_STOP]);
    wr(`CTRL_OFFSET, 32'hf);
    rd(`STAT1_OFFSET, v);
    chk_bit("stop clr", 1'b0, v[`STAT1_STOP]);
    rd(`IRQ_STATUS_OFFSET, v);
    chk_bit("stop irq", 1'b1, v[`IRQ_STOP]);
    wr(`IRQ_STATUS_OFFSET, 32'h7);
    @(posedge clk);
    chk_bit("irq low", 1'b0, irq);
  endtask
  // Ack and buffer interrupt both off for the data byte
  task automatic t_nack();
    fork
      begin
        i2c_master_model_i.start();
        i2c_master_model_i.write_byte(8'h54, a0);
        i2c_master_model_i.write_byte(8'h81, a1);
        i2c_master_model_i.stop();
      end
      begin
        wait_stat1(`STAT1_ADDR_MATCHED, v);
        rd(`STAT2_OFFSET, v);
        wr(`CTRL_OFFSET, 32'h5);
        wait_stat1(`STAT1_RX_AVAIL, v);
        rd(`DATA_OFFSET, v);
        chk_word("nack byte", 32'h81, v);
        rd(`IRQ_STATUS_OFFSET, v);
        chk_bit("rx irq off", 1'b0, v[`IRQ_RX]);
      end
    join
    chk_bit("nack", 1'b1, a1);
    wait_stat1(`STAT1_STOP, v);
    wr(`CTRL_OFFSET, 32'hf);
  endtask
  task automatic summarize();
    n_errors += i2c_master_model_i.n_timeouts;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_frame();
    t_nack();
    summarize();
  end
endmodule
